// File: tli_pkg.sv
`default_nettype none
package tli_pkg;

    // ****************************************
    // Sizes and source placement
    // ****************************************
    localparam int          NUM_SRC   = 22;
    localparam int          IDX_W     = 5;
    localparam int          EXT0_IDX  = 0;
    localparam int          EXT1_IDX  = 2;

    // ****************************************
    // Vector layout and reset values
    // ****************************************
    localparam logic [15:0] VEC_BASE    = 16'h0003;
    localparam logic [15:0] VEC_STEP    = 16'h0008;
    localparam logic [21:0] HW_CLR_MASK = 22'h00000f;
    localparam logic [21:0] PEND_RST    = 22'h000000;
    localparam logic [21:0] PRIO_RST    = 22'h000000;
    localparam logic [15:0] VEC_RST     = 16'h0000;

    typedef enum {
        tli_st_idle,
        tli_st_req
    } tli_st_t;

    // Entry address of a source's service routine
    function automatic logic [15:0] tli_vec_addr(input logic [IDX_W-1:0] idx);
        tli_vec_addr = VEC_BASE + VEC_STEP * {11'h000, idx};
    endfunction

endpackage
`default_nettype wire

// File: tli_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tli_sync #(
    parameter int W = 2
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] level_q,
    output var  logic [W-1:0] fall_q
);

    if (W < 1) begin : g_chk
        $error("tli_sync: W must be positive");
    end

    // ****************************************
    // Two-stage capture of asynchronous pins
    // ****************************************
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // Idle pins are high, so reset to high avoids a false edge at release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
            prev_r <= {W{1'b1}};
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_q = sync_r;
    assign fall_q  = prev_r & ~sync_r;

endmodule
`default_nettype wire

// File: tli_arb.sv
`timescale 1ns/100ps
`default_nettype none
module tli_arb
    import tli_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic [N-1:0]     req_hi,
    input  wire logic [N-1:0]     req_lo,
    output var  logic             found,
    output var  logic [IDX_W-1:0] win_idx,
    output var  logic             win_hi
);

    // Index field must be able to name every source
    if (N < 1 || N > (1 << IDX_W)) begin : g_chk
        $error("tli_arb: N out of range");
    end

    // ****************************************
    // Level first, then lowest index wins
    // ****************************************
    always_comb begin
        found   = 1'b0;
        win_idx = '0;
        win_hi  = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_lo[i]) begin
                found   = 1'b1;
                win_idx = IDX_W'(i);
            end
        end
        // High level overrides anything found at low level
        for (int i = N - 1; i >= 0; i--) begin
            if (req_hi[i]) begin
                found   = 1'b1;
                win_idx = IDX_W'(i);
                win_hi  = 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: tli_ctrl.sv
// What this block does
// - Twenty-two sources, each set to high or low priority level.
// - A valid source condition sets that source's pending flag.
// - An enabled, set pending flag raises a request to the CPU.
// - CPU finishes current instruction, then long-calls the source's fixed vector.
// - Return from service resumes the instruction that would have run next.
// - Flags set even when disabled; disabled flags never raise a request.
// - Every source has its own independent enable bit.
// - Source enables count only while the global enable is one.
// - Global enable at zero blocks every source.
// - Some flags clear by hardware on vectoring; others need software clear.
// - Flag still set after return re-enters after one further instruction.
// - Software writing one to a flag acts like a hardware event.
// - High level preempts low; high is never preempted; default is low.
// - Simultaneous requests: higher level first, then fixed source order.
`timescale 1ns/100ps
`default_nettype none
module tli_ctrl
    import tli_pkg::*;
#(
    parameter int               N_SRC  = NUM_SRC,
    parameter logic [N_SRC-1:0] HW_CLR = HW_CLR_MASK[N_SRC-1:0]
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [N_SRC-1:0] src_event,
    input  wire logic [N_SRC-1:0] sw_set,
    input  wire logic [N_SRC-1:0] sw_clr,
    input  wire logic [1:0]       ext_int_n,
    input  wire logic [1:0]       ext_edge_mode,
    input  wire logic             global_irq_enable,
    input  wire logic [N_SRC-1:0] src_enable,
    input  wire logic [N_SRC-1:0] src_prio,
    input  wire logic             prio_wr,
    input  wire logic             instr_boundary,
    input  wire logic             long_call_instr,
    input  wire logic             return_from_service_instr,
    output var  logic             irq_req_r,
    output var  logic [IDX_W-1:0] irq_src_r,
    output var  logic [15:0]      irq_vector_r,
    output var  logic             irq_level_r,
    output var  logic [N_SRC-1:0] pend_r,
    output var  logic             act_hi_r,
    output var  logic             act_lo_r
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (N_SRC < 3 || N_SRC > NUM_SRC) begin : g_chk
        $error("tli_ctrl: N_SRC out of range");
    end

    function automatic logic [N_SRC-1:0] src_bit(input logic [IDX_W-1:0] i);
        src_bit    = '0;
        src_bit[i] = 1'b1;
    endfunction

    // ****************************************
    // External pins
    // ****************************************
    logic [1:0]       ext_q;
    logic [1:0]       ext_fall;
    logic [N_SRC-1:0] ext_edge_set;
    logic [N_SRC-1:0] ext_lvl_mask;
    logic [N_SRC-1:0] ext_lvl_val;

    tli_sync #(.W(2)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (ext_int_n),
        .level_q (ext_q),
        .fall_q  (ext_fall)
    );

    // Level mode: flag simply follows the pin, so the source must drop it in time
    always_comb begin
        ext_edge_set           = '0;
        ext_lvl_mask           = '0;
        ext_lvl_val            = '0;
        ext_edge_set[EXT0_IDX] = ext_edge_mode[0] & ext_fall[0];
        ext_edge_set[EXT1_IDX] = ext_edge_mode[1] & ext_fall[1];
        ext_lvl_mask[EXT0_IDX] = ~ext_edge_mode[0];
        ext_lvl_mask[EXT1_IDX] = ~ext_edge_mode[1];
        ext_lvl_val[EXT0_IDX]  = ~ext_q[0];
        ext_lvl_val[EXT1_IDX]  = ~ext_q[1];
    end

    // ****************************************
    // Pending flags
    // ****************************************
    logic             ack_take;
    logic [N_SRC-1:0] hw_clr;
    logic [N_SRC-1:0] pend_set;
    logic [N_SRC-1:0] pend_nxt;

    assign ack_take = long_call_instr & irq_req_r;
    assign hw_clr   = ack_take ? (HW_CLR & src_bit(irq_src_r)) : '0;
    assign pend_set = src_event | sw_set | ext_edge_set;

    always_comb begin
        pend_nxt = (pend_r & ~(sw_clr | hw_clr)) | pend_set;
        pend_nxt = (pend_nxt & ~ext_lvl_mask) | (ext_lvl_val & ext_lvl_mask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_r <= PEND_RST[N_SRC-1:0];
        end else begin
            pend_r <= pend_nxt;
        end
    end

    logic [N_SRC-1:0] prio_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prio_r <= PRIO_RST[N_SRC-1:0];
        end else if (prio_wr) begin
            prio_r <= src_prio;
        end
    end

    // ****************************************
    // Eligibility and arbitration
    // ****************************************
    logic [N_SRC-1:0] elig;
    logic [N_SRC-1:0] elig_hi;
    logic [N_SRC-1:0] elig_lo;
    logic             found;
    logic [IDX_W-1:0] win_idx;
    logic             win_hi;

    assign elig    = pend_r & src_enable & {N_SRC{global_irq_enable}};
    assign elig_hi = act_hi_r ? '0 : (elig & prio_r);
    assign elig_lo = (act_hi_r | act_lo_r) ? '0 : (elig & ~prio_r);

    tli_arb #(.N(N_SRC)) u_arb (
        .req_hi  (elig_hi),
        .req_lo  (elig_lo),
        .found   (found),
        .win_idx (win_idx),
        .win_hi  (win_hi)
    );

    // ****************************************
    // Request sequencing
    // ****************************************
    tli_st_t st_r;
    logic    skip_r;
    logic    sample_ok;

    assign sample_ok = instr_boundary & (st_r == tli_st_idle) & ~skip_r
                       & ~return_from_service_instr;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            skip_r <= 1'b0;
        end else if (return_from_service_instr) begin
            skip_r <= 1'b1;
        end else if (instr_boundary) begin
            skip_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= tli_st_idle;
        end else begin
            case (st_r)
                tli_st_idle: begin
                    if (sample_ok && found) begin
                        st_r <= tli_st_req;
                    end
                end
                tli_st_req: begin
                    if (long_call_instr) begin
                        st_r <= tli_st_idle;
                    end
                end
                default: begin
                    st_r <= tli_st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_req_r    <= 1'b0;
            irq_src_r    <= '0;
            irq_vector_r <= VEC_RST;
            irq_level_r  <= 1'b0;
        end else if (sample_ok && found) begin
            irq_req_r    <= 1'b1;
            irq_src_r    <= win_idx;
            irq_vector_r <= tli_vec_addr(win_idx);
            irq_level_r  <= win_hi;
        end else if (ack_take) begin
            irq_req_r    <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_hi_r <= 1'b0;
            act_lo_r <= 1'b0;
        end else begin
            if (return_from_service_instr) begin
                if (act_hi_r) begin
                    act_hi_r <= 1'b0;
                end else begin
                    act_lo_r <= 1'b0;
                end
            end
            if (ack_take) begin
                if (irq_level_r) begin
                    act_hi_r <= 1'b1;
                end else begin
                    act_lo_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_raise;
        $rose(irq_req_r);
    endsequence

    sequence s_enter;
        long_call_instr && irq_req_r;
    endsequence

    src_range_a: assert property (irq_req_r |-> irq_src_r < IDX_W'(N_SRC))
        else $error("request names a missing source");

    flag_set_a: assert property (pend_set != '0 |=>
        (pend_r & $past(pend_set & ~ext_lvl_mask)) == $past(pend_set & ~ext_lvl_mask))
        else $error("pending flag not set by event");

    raise_vec_a: assert property (sample_ok && found |=>
        irq_req_r && irq_src_r == $past(win_idx) && irq_vector_r == tli_vec_addr(irq_src_r))
        else $error("request or vector missing");

    enter_a: assert property (s_enter |=> !irq_req_r && (act_hi_r || act_lo_r))
        else $error("long call did not enter routine");

    leave_a: assert property (return_from_service_instr && !long_call_instr && act_hi_r
        |=> !act_hi_r)
        else $error("return did not leave routine");

    disabled_a: assert property (s_raise |->
        ($past(elig) & src_bit(irq_src_r)) != '0)
        else $error("request from disabled source");

    gie_off_a: assert property (!global_irq_enable && instr_boundary |=> !$rose(irq_req_r))
        else $error("request while globally disabled");

    hw_clr_a: assert property ((s_enter and ((HW_CLR & src_bit(irq_src_r)) != '0
        && (pend_set & src_bit(irq_src_r)) == '0 && (ext_lvl_mask & src_bit(irq_src_r)) == '0))
        |=> (pend_r & $past(src_bit(irq_src_r))) == '0)
        else $error("hardware clear missed");

    return_from_service_instr_skip_a: assert property (return_from_service_instr && !irq_req_r
        ##1 (instr_boundary && !return_from_service_instr) |=> !irq_req_r)
        else $error("re-entry without one more instruction");

    sw_set_a: assert property ((sw_set & ~ext_lvl_mask) != '0
        |=> (pend_r & $past(sw_set) & ~$past(ext_lvl_mask)) != '0)
        else $error("software set lost");

    preempt_a: assert property (s_raise |-> !act_hi_r && (irq_level_r || !act_lo_r))
        else $error("illegal preemption");

    order_a: assert property ((s_raise and !irq_level_r) |-> $past(elig_hi) == '0)
        else $error("low level taken over high");

    boundary_a: assert property (s_raise |-> $past(instr_boundary))
        else $error("request off boundary");

endmodule
`default_nettype wire

// File: tli_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Instruction sequencer model
// ****************************************
module tli_cpu_model #(
    parameter int BND_PERIOD = 4
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic irq_req_r,
    input  wire logic ret_go,
    output var  logic instr_boundary,
    output var  logic long_call_instr,
    output var  logic return_from_service_instr
);
    int cnt;
    logic go;

    // Outputs move just after the edge so the design samples them settled
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt = 0;
            instr_boundary = 1'b0;
            long_call_instr = 1'b0;
            return_from_service_instr = 1'b0;
        end else begin
            // Take the command at the edge, before the bench moves it
            go = ret_go;
            #1;
            long_call_instr = (irq_req_r === 1'b1) && instr_boundary && !long_call_instr;
            cnt = (cnt == BND_PERIOD - 1) ? 0 : cnt + 1;
            instr_boundary = (cnt == 0);
            return_from_service_instr = go;
        end
    end
endmodule
`default_nettype wire

// File: two_level_interrupt_handler_test.sv
`timescale 1ns/100ps
`default_nettype none
module two_level_interrupt_handler_test;
    import tli_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 rst = 1'b1;
    logic [NUM_SRC-1:0]   src_event = '0;
    logic [NUM_SRC-1:0]   sw_set = '0;
    logic [NUM_SRC-1:0]   sw_clr = '0;
    logic [1:0]           ext_int_n = 2'b11;
    logic [1:0]           ext_mode = 2'b11;
    logic                 global_irq_enable = 1'b0;
    logic [NUM_SRC-1:0]   src_enable = '0;
    logic [NUM_SRC-1:0]   src_prio = '0;
    logic                 prio_wr = 1'b0;
    logic                 ret_go = 1'b0;
    logic                 bnd, lc, rsi, req, lvl, ahi, alo;
    logic [IDX_W-1:0]     src;
    logic [15:0]          vec;
    logic [NUM_SRC-1:0]   pend;
    int                   miscompares = 0;
    int                   total_checks = 0;
    int                   cycles = 0;

    // ****************************************
    // Clock, units and watchdog
    // ****************************************
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    tli_ctrl i_tli_ctrl (.sys_clk(sys_clk), .rst(rst), .src_event(src_event), .sw_set(sw_set),
        .sw_clr(sw_clr), .ext_int_n(ext_int_n), .ext_edge_mode(ext_mode),
        .global_irq_enable(global_irq_enable), .src_enable(src_enable), .src_prio(src_prio),
        .prio_wr(prio_wr), .instr_boundary(bnd), .long_call_instr(lc),
        .return_from_service_instr(rsi), .irq_req_r(req), .irq_src_r(src),
        .irq_vector_r(vec), .irq_level_r(lvl), .pend_r(pend), .act_hi_r(ahi), .act_lo_r(alo));

    tli_cpu_model i_tli_cpu_model (.sys_clk(sys_clk), .rst(rst), .irq_req_r(req),
        .ret_go(ret_go), .instr_boundary(bnd), .long_call_instr(lc),
        .return_from_service_instr(rsi));

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic ev(input logic [NUM_SRC-1:0] m);
        src_event = m;
        tick(1);
        src_event = '0;
    endtask

    task automatic sset(input logic [NUM_SRC-1:0] m);
        sw_set = m;
        tick(1);
        sw_set = '0;
    endtask

    task automatic sclr(input logic [NUM_SRC-1:0] m);
        sw_clr = m;
        tick(1);
        sw_clr = '0;
    endtask

    // Bounded wait; expects source, vector and level of the request
    task automatic req_is(input logic [IDX_W-1:0] s, input logic l);
        int k;
        k = 0;
        while (req !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        check("request", req, 1'b1);
        check("source", src, s);
        check("vector", vec, VEC_BASE + VEC_STEP * s);
        check("level", lvl, l);
        tick(8);
        check("request after call", req, 1'b0);
    endtask

    task automatic ret_pulse();
        ret_go = 1'b1;
        tick(1);
        ret_go = 1'b0;
    endtask

    task automatic do_ret();
        ret_pulse();
        tick(10);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check("pending at reset", pend, PEND_RST);
        check("request at reset", {req, ahi, alo}, 3'h0);
    endtask

    task automatic t_gate();
        ev(22'h000020);
        check("flag while disabled", pend[5], 1'b1);
        src_enable = 22'h000040;
        global_irq_enable = 1'b1;
        tick(10);
        check("other enable only", req, 1'b0);
        src_enable = 22'h000020;
        global_irq_enable = 1'b0;
        tick(10);
        check("global off", req, 1'b0);
        global_irq_enable = 1'b1;
        req_is(5'h05, 1'b0);
        sclr(22'h000020);
        do_ret();
    endtask

    task automatic t_vector();
        src_enable = 22'h000028;
        ev(22'h000028);
        req_is(5'h03, 1'b0);
        check("hw cleared flag", pend[3], 1'b0);
        check("sw cleared flag", pend[5], 1'b1);
        check("low in service", {ahi, alo, req}, 3'h2);
        sclr(22'h000020);
        do_ret();
        check("low after return", alo, 1'b0);
    endtask

    task automatic t_resume();
        src_enable = 22'h000080;
        sset(22'h000080);
        req_is(5'h07, 1'b0);
        check("flag kept", pend[7], 1'b1);
        ret_pulse();
        repeat (5) begin
            tick(1);
            check("one instruction first", req, 1'b0);
        end
        req_is(5'h07, 1'b0);
        sclr(22'h000080);
        do_ret();
    endtask

    task automatic t_prio();
        src_prio = 22'h000200;
        prio_wr = 1'b1;
        tick(1);
        prio_wr = 1'b0;
        src_enable = 22'h000210;
        ev(22'h000210);
        req_is(5'h09, 1'b1);
        check("high blocks low", {ahi, req}, 2'h2);
        sclr(22'h000200);
        ret_pulse();
        req_is(5'h04, 1'b0);
        sset(22'h000200);
        req_is(5'h09, 1'b1);
        check("both in service", {ahi, alo}, 2'h3);
        sclr(22'h000210);
        do_ret();
        do_ret();
        check("all returned", {ahi, alo, req}, 3'h0);
    endtask

    task automatic t_ext();
        ext_int_n = 2'b01;
        tick(6);
        check("pin fall flag", pend[EXT1_IDX], 1'b1);
        ext_int_n = 2'b11;
        sclr(22'h000004);
        check("pin flag cleared", pend[EXT1_IDX], 1'b0);
        ext_mode = 2'b10;
        ext_int_n = 2'b10;
        tick(4);
        check("pin level flag", pend[EXT0_IDX], 1'b1);
        sclr(22'h000001);
        check("level ignores clear", pend[EXT0_IDX], 1'b1);
        ext_int_n = 2'b11;
        tick(4);
        check("level flag follows pin", pend[EXT0_IDX], 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_gate();
        t_vector();
        t_resume();
        t_prio();
        t_ext();
        end_sim();
    end
endmodule
`default_nettype wire
